/* File: inc/plmtb_pkg.sv */
// package: offsets, field layout, reset values and types of the line monitor
package plmtb_pkg;

  // register map, link-side 6-bit address space
  localparam int          ADDR_W         = 6;
  localparam int          DATA_W         = 8;
  localparam logic [5:0]  OFS_LINE_MON   = 6'h15;
  localparam logic [5:0]  OFS_TEST       = 6'h16;
  localparam logic [5:0]  OFS_TEST_SET   = 6'h17;
  localparam logic [5:0]  OFS_TEST_CLR   = 6'h18;

  // line monitor field layout
  localparam int          MON_DP_BIT     = 0;
  localparam int          MON_DM_BIT     = 1;
  localparam int          MON_FIELD_W    = 2;

  // reset values
  localparam logic [7:0]  RST_TEST       = 8'h00;
  localparam logic [1:0]  RST_LINE_FIELD = 2'h0;
  localparam logic [7:0]  RST_RDATA      = 8'h00;
  localparam logic [7:0]  UNMAPPED_RDATA = 8'h00;

  // pin synchroniser depth and cycles until its output is live
  localparam int          SYNC_STAGES    = 3;
  localparam int          SETTLE_CYCLES  = SYNC_STAGES + 1;

  // receiver pins, sampled together
  typedef struct packed {
    logic hs_diff;
    logic dm;
    logic dp;
  } plmtb_line_t;

  // one register access from the link side
  typedef struct packed {
    logic [5:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } plmtb_req_t;

  typedef enum logic [1:0] {
    SPD_LOW   = 2'b00,
    SPD_FULL  = 2'b01,
    SPD_HIGH  = 2'b10,
    SPD_CHIRP = 2'b11
  } plmtb_speed_t;

  // meaning of the line field under the present speed
  typedef enum logic [2:0] {
    COND_SE0      = 3'b000,
    COND_J        = 3'b001,
    COND_K        = 3'b010,
    COND_SE1      = 3'b011,
    COND_SQUELCH  = 3'b100,
    COND_ACTIVE   = 3'b101,
    COND_CHIRP_HI = 3'b110,
    COND_INVALID  = 3'b111
  } plmtb_cond_t;

endpackage : plmtb_pkg

/* File: verilog/plmtb_line_sync.sv */
// module: three-stage pin synchroniser with agreement filter and settle flag
`timescale 1ns/10ps
module plmtb_line_sync
  import plmtb_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic                  settled
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [2:0]       settle_cnt;

  localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_CYCLES - 1);

  if (SETTLE_CYCLES > 7) begin : g_chk
    $error("settle count does not fit its counter");
  end

  // stage1 is read only by stage2, never by the filter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= '0;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end

  // live output is trusted once the pipeline has been refilled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_cnt <= 3'h0;
      settled    <= 1'b0;
    end else if (!settled) begin
      settle_cnt <= settle_cnt + 3'h1;
      settled    <= (settle_cnt == SETTLE_LAST);
    end
  end

endmodule : plmtb_line_sync

/* File: verilog/plmtb_regs.sv */
// module: line monitor view and test byte registers of the transceiver
//
// Functional notes
// R1: monitor bits follow positive and negative lines
// R2: monitor register is read-only, writes discarded
// R3: value 0 is SE0 or squelch
// R4: value 1 is K/J/active/chirp-high by speed
// R5: value 2 is J/K/invalid/active by speed
// R6: value 3 is SE1, else invalid
// R7: test byte resets zero, holds writes
// R8: test byte never affects line behaviour
// R9: set alias sets bits written one
// R10: clear alias clears bits written one
// R11: aliases read back the single test byte
// R12: monitor bits 7:2 always read zero
// R13: monitor reads zero only until receivers settle
`timescale 1ns/10ps
module plmtb_regs
  import plmtb_pkg::*;
#(
  parameter int REG_DATA_W = DATA_W
) (
  input  wire logic         REF_CLK,
  input  wire logic         RST_N,
  input  wire plmtb_req_t   REG_REQ,
  input  wire plmtb_line_t  LINE_PINS,
  input  wire plmtb_speed_t SPEED_MODE,
  output logic [7:0]        REG_RDATA,
  output logic              REG_RVALID,
  output plmtb_cond_t       LINE_COND,
  output logic              LINE_SETTLED
);

  if (REG_DATA_W != DATA_W) begin : g_chk_width
    $error("register data path must be eight bits wide");
  end

  plmtb_line_t      line_level;
  logic             settled;
  logic [7:0]       test_byte;
  logic [7:0]       next_test_byte;
  logic [1:0]       line_field;
  logic [7:0]       mon_value;

  // receiver outputs come from the analog front end, not from REF_CLK
  plmtb_line_sync #(
    .WIDTH   ($bits(plmtb_line_t))
  ) u_sync (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .pin_in  (LINE_PINS),
    .level   (line_level),
    .settled (settled)
  );

  // read data for one address; unmapped addresses read as zero
  function automatic logic [7:0] read_value(
    input logic [5:0] addr,
    input logic [7:0] mon,
    input logic [7:0] tbyte
  );
    logic [7:0] val;
    val = UNMAPPED_RDATA;
    case (addr)
      OFS_LINE_MON: val = mon;
      OFS_TEST:     val = tbyte;      // see R11
      OFS_TEST_SET: val = tbyte;      // see R11
      OFS_TEST_CLR: val = tbyte;      // see R11
      default:      val = UNMAPPED_RDATA;
    endcase
    return val;
  endfunction : read_value

  // meaning of a line field value at a given speed
  function automatic plmtb_cond_t decode_line(
    input logic [1:0]   code,
    input plmtb_speed_t spd,
    input logic         diff
  );
    plmtb_cond_t c;
    c = COND_INVALID;
    case (code)
      2'h0: c = (spd == SPD_LOW || spd == SPD_FULL) ?
                COND_SE0 : COND_SQUELCH;        // see R3
      2'h1: begin
        case (spd)
          SPD_LOW:   c = COND_K;                // see R4
          SPD_FULL:  c = COND_J;                // see R4
          SPD_HIGH:  c = COND_ACTIVE;           // see R4
          SPD_CHIRP: c = diff ? COND_CHIRP_HI : COND_INVALID; // see R4
          default:   c = COND_INVALID;
        endcase
      end
      2'h2: begin
        case (spd)
          SPD_LOW:   c = COND_J;                // see R5
          SPD_FULL:  c = COND_K;                // see R5
          SPD_HIGH:  c = COND_INVALID;          // see R5
          SPD_CHIRP: c = diff ? COND_INVALID : COND_ACTIVE; // see R5
          default:   c = COND_INVALID;
        endcase
      end
      2'h3: c = (spd == SPD_LOW || spd == SPD_FULL) ?
                COND_SE1 : COND_INVALID;        // see R6
      default: c = COND_INVALID;
    endcase
    return c;
  endfunction : decode_line

  // live field; held at its reset value until the pipeline refills
  always_comb begin
    line_field = RST_LINE_FIELD;
    if (settled) begin                         // see R13
      line_field[MON_DP_BIT] = line_level.dp;  // see R1
      line_field[MON_DM_BIT] = line_level.dm;  // see R1
    end
  end

  // reserved upper bits are constant zero, no storage behind them
  always_comb begin
    mon_value = 8'h00;                         // see R12
    mon_value[MON_FIELD_W-1:0] = line_field;   // see R2
  end

  // test byte write, set and clear; a write to the monitor lands nowhere
  always_comb begin
    next_test_byte = test_byte;
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        OFS_TEST:     next_test_byte = REG_REQ.wdata;  // see R7
        OFS_TEST_SET: next_test_byte = test_byte | REG_REQ.wdata; // see R9
        OFS_TEST_CLR: next_test_byte = test_byte & ~REG_REQ.wdata; // see R10
        default:      next_test_byte = test_byte;      // see R2
      endcase
    end
  end

  // the byte feeds only the read mux, so line logic never sees it
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      test_byte <= RST_TEST;                   // see R7
    end else begin
      test_byte <= next_test_byte;             // see R8
    end
  end

  // read answer one cycle after the strobe; a write in the same cycle
  // is seen by the following read, not this one
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      REG_RDATA  <= RST_RDATA;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
      if (REG_REQ.rd) begin
        REG_RDATA <= read_value(REG_REQ.addr, mon_value, test_byte);
      end
    end
  end

  // decoded line condition, registered for a clean output
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      LINE_COND    <= COND_SE0;
      LINE_SETTLED <= 1'b0;
    end else begin
      LINE_COND    <= decode_line(line_field, SPEED_MODE,
                                  line_level.hs_diff);
      LINE_SETTLED <= settled;
    end
  end

  // ---- assertions ----
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_rd_mon;
    REG_REQ.rd && REG_REQ.addr == OFS_LINE_MON;
  endsequence

  sequence s_rd_alias;
    REG_REQ.rd &&
      (REG_REQ.addr == OFS_TEST_SET || REG_REQ.addr == OFS_TEST_CLR);
  endsequence

  sequence s_wr_to(logic [5:0] a);
    REG_REQ.wr && REG_REQ.addr == a;
  endsequence

  sequence s_lowfull;
    settled && (SPEED_MODE == SPD_LOW || SPEED_MODE == SPD_FULL);
  endsequence

  a_mon_live_bits: assert property ( // see R1
    s_rd_mon ##0 settled |=>
      REG_RVALID && REG_RDATA[0] == $past(line_level.dp) &&
      REG_RDATA[1] == $past(line_level.dm))
    else $error("monitor bits do not follow the lines");

  a_mon_ignores_wr: assert property ( // see R2
    s_wr_to(OFS_LINE_MON) ##0 !REG_REQ.rd |=> $stable(test_byte))
    else $error("write to monitor changed stored state");

  a_cond_zero: assert property ( // see R3
    settled && line_field == 2'h0 |=>
      LINE_COND == ($past(SPEED_MODE) == SPD_LOW ||
                    $past(SPEED_MODE) == SPD_FULL ? COND_SE0 : COND_SQUELCH))
    else $error("value zero decoded wrongly");

  a_cond_one_lf: assert property ( // see R4
    s_lowfull ##0 line_field == 2'h1 |=>
      LINE_COND == ($past(SPEED_MODE) == SPD_LOW ? COND_K : COND_J))
    else $error("value one decoded wrongly");

  a_cond_two_lf: assert property ( // see R5
    s_lowfull ##0 line_field == 2'h2 |=>
      LINE_COND == ($past(SPEED_MODE) == SPD_LOW ? COND_J : COND_K))
    else $error("value two decoded wrongly");

  a_cond_three: assert property ( // see R6
    settled && line_field == 2'h3 |=>
      LINE_COND == ($past(SPEED_MODE) == SPD_LOW ||
                    $past(SPEED_MODE) == SPD_FULL ? COND_SE1 : COND_INVALID))
    else $error("value three decoded wrongly");

  a_test_write: assert property ( // see R7
    s_wr_to(OFS_TEST) ##1 REG_REQ.rd && REG_REQ.addr == OFS_TEST |=>
      REG_RDATA == $past(REG_REQ.wdata, 2))
    else $error("test byte does not hold the written value");

  a_test_set: assert property ( // see R9
    s_wr_to(OFS_TEST_SET) |=>
      test_byte == ($past(test_byte) | $past(REG_REQ.wdata)))
    else $error("set alias did not set bits");

  a_test_clr: assert property ( // see R10
    s_wr_to(OFS_TEST_CLR) |=>
      test_byte == ($past(test_byte) & ~$past(REG_REQ.wdata)))
    else $error("clear alias did not clear bits");

  a_alias_read: assert property ( // see R11
    s_rd_alias |=> REG_RVALID && REG_RDATA == $past(test_byte))
    else $error("alias read differs from test byte");

  a_mon_reserved: assert property ( // see R12
    s_rd_mon |=> REG_RDATA[7:2] == 6'h00)
    else $error("reserved monitor bits not zero");

  a_mon_presettle: assert property ( // see R13
    s_rd_mon ##0 !settled |=> REG_RDATA == 8'h00)
    else $error("monitor not zero before receivers settle");

  a_settle_time: assert property ( // see R13
    $rose(RST_N) |-> ##[1:6] settled)
    else $error("receivers never reported settled");

endmodule : plmtb_regs

/* File: tb/plmtb_link_model.sv */
// link-side model: register requests driven just after the rising edge
`timescale 1ns/10ps
module plmtb_link_model
  import plmtb_pkg::*;
(
  input  wire logic REF_CLK,
  output plmtb_req_t REG_REQ
);
  initial REG_REQ = '0;

  // one request, held unchanged through exactly one sampling edge
  task automatic acc(input logic r, input logic w,
                     input logic [5:0] a, input logic [7:0] d);
    REG_REQ.addr  = a;
    REG_REQ.rd    = r;
    REG_REQ.wr    = w;
    REG_REQ.wdata = d;
    @(posedge REF_CLK);
    #1;
  endtask : acc

  // released: address and data flip so a stale value never looks valid
  task automatic idle();
    REG_REQ.rd    = 1'b0;
    REG_REQ.wr    = 1'b0;
    REG_REQ.addr  = ~REG_REQ.addr;
    REG_REQ.wdata = ~REG_REQ.wdata;
  endtask : idle
endmodule : plmtb_link_model

/* File: tb/plmtb_regs_bench.sv */
// testbench: register map, aliases and line decode of the monitor block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module plmtb_regs_bench
  import plmtb_pkg::*;
;
  logic         REF_CLK, RST_N, REG_RVALID, LINE_SETTLED;
  plmtb_req_t   REG_REQ;
  plmtb_line_t  LINE_PINS;
  plmtb_speed_t SPEED_MODE;
  logic [7:0]   REG_RDATA;
  plmtb_cond_t  LINE_COND;
  int           fail_count = 0;
  int           n_compared = 0;
  logic [7:0]   exp_q[$];
  logic [7:0]   mirror = 8'h00;
  logic [7:0]   lfsr_state = 8'h3b;
  logic         live = 1'b0;

  plmtb_link_model link (.REF_CLK(REF_CLK), .REG_REQ(REG_REQ));
  plmtb_regs DUT (.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_REQ(REG_REQ),
    .LINE_PINS(LINE_PINS), .SPEED_MODE(SPEED_MODE), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .LINE_COND(LINE_COND),
    .LINE_SETTLED(LINE_SETTLED));

  initial REF_CLK = 1'b0;
  always #10 REF_CLK = ~REF_CLK;

  function automatic logic [7:0] lfsr();
    lfsr_state = {lfsr_state[6:0],
                  lfsr_state[7] ^ lfsr_state[5] ^ lfsr_state[4] ^ lfsr_state[3]};
    return lfsr_state;
  endfunction : lfsr

  // expected decode of the two-bit line field per speed
  function automatic plmtb_cond_t cond_of(input logic [1:0] c,
                                          input plmtb_speed_t s, input logic h);
    case (s)
      SPD_LOW:  return (c == 2'h1) ? COND_K : (c == 2'h2) ? COND_J :
                       plmtb_cond_t'({1'b0, c});
      SPD_FULL: return plmtb_cond_t'({1'b0, c});
      SPD_HIGH: return (c == 2'h0) ? COND_SQUELCH :
                       (c == 2'h1) ? COND_ACTIVE : COND_INVALID;
      default:  return (c == 2'h0) ? COND_SQUELCH :
                       (c == 2'h1 && h) ? COND_CHIRP_HI :
                       (c == 2'h2 && !h) ? COND_ACTIVE : COND_INVALID;
    endcase
  endfunction : cond_of

  function automatic logic [7:0] expect_rd(input logic [5:0] a);
    if (a == OFS_LINE_MON) return live ? {6'h00, LINE_PINS.dm, LINE_PINS.dp}
                                       : 8'h00;
    if (a >= OFS_TEST && a <= OFS_TEST_CLR) return mirror;
    return 8'h00;
  endfunction : expect_rd

  // read expectation is taken before the write lands: same-cycle rd+wr
  task automatic acc(input logic r, input logic w,
                     input logic [5:0] a, input logic [7:0] d);
    if (r) exp_q.push_back(expect_rd(a));
    if (w && a == OFS_TEST) mirror = d;
    if (w && a == OFS_TEST_SET) mirror = mirror | d;
    if (w && a == OFS_TEST_CLR) mirror = mirror & ~d;
    link.acc(r, w, a, d);
  endtask : acc

  // answers are one-cycle pulses, so the falling edge sees each exactly once
  always @(negedge REF_CLK) begin
    logic [7:0] e;
    if (REG_RVALID === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("MISMATCH REG_RVALID exp 0 got 1");
      end else begin
        e = exp_q.pop_front();
        `CHK("REG_RDATA", e, REG_RDATA)
      end
    end
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #200000;
    fail_count++;
    final_report();
  end

  initial begin
    RST_N = 1'b0;
    LINE_PINS = 3'b011;
    SPEED_MODE = SPD_FULL;
    repeat (2) @(posedge REF_CLK);
    #1 RST_N = 1'b1;
    acc(1'b1, 1'b0, OFS_LINE_MON, 8'h00);
    acc(1'b1, 1'b0, OFS_TEST, 8'h00);
    acc(1'b0, 1'b1, OFS_TEST, lfsr());
    acc(1'b1, 1'b0, OFS_TEST, 8'h00);
    acc(1'b1, 1'b1, OFS_TEST, 8'h5a);
    acc(1'b0, 1'b1, OFS_TEST_SET, 8'h81);
    acc(1'b1, 1'b0, OFS_TEST_SET, 8'h00);
    acc(1'b0, 1'b1, OFS_TEST_CLR, 8'h0f);
    acc(1'b1, 1'b0, OFS_TEST_CLR, 8'h00);
    acc(1'b0, 1'b1, OFS_LINE_MON, 8'hff);
    acc(1'b0, 1'b1, 6'h3f, 8'hff);
    acc(1'b1, 1'b0, 6'h3f, 8'h00);
    link.idle();
    @(posedge REF_CLK);
    #1;
    `CHK("LINE_SETTLED", 1'b1, LINE_SETTLED)
    live = 1'b1;
    // every speed, line code and receiver level, with test byte churn
    for (int i = 0; i < 32; i++) begin
      LINE_PINS = plmtb_line_t'(i[2:0]);
      LINE_PINS.hs_diff = i[4];
      SPEED_MODE = plmtb_speed_t'(i[3:2]);
      acc(1'b0, 1'b1, OFS_TEST, lfsr());
      link.idle();
      repeat (8) @(posedge REF_CLK);
      #1;
      `CHK("LINE_COND", cond_of(i[1:0], SPEED_MODE, i[4]), LINE_COND)
      acc(1'b1, 1'b0, OFS_LINE_MON, 8'h00);
      acc(1'b1, 1'b0, OFS_TEST_SET, 8'h00);
      link.idle();
      @(posedge REF_CLK);
      #1;
    end
    // mid-run reset: monitor goes back to zero until the pipeline refills
    RST_N = 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1 RST_N = 1'b1;
    live = 1'b0;
    mirror = RST_TEST;
    acc(1'b1, 1'b0, OFS_LINE_MON, 8'h00);
    acc(1'b1, 1'b0, OFS_TEST, 8'h00);
    link.idle();
    repeat (4) @(posedge REF_CLK);
    `CHK("pending reads", 0, exp_q.size())
    final_report();
  end
endmodule : plmtb_regs_bench
